//--- hw/p8g_map.svh
`ifndef P8G_MAP_SVH
`define P8G_MAP_SVH

// Register indexes; byte address is four times the index
`define P8G_IDX_DIRECTION   20'h0_EE007
`define P8G_IDX_OUT_DATA    20'h0_FFFD7
`define P8G_IDX_DRAM_CTRL   20'h0_0100
`define P8G_IDX_IRQ_ENABLE  20'h0_0101
`define P8G_IDX_STATUS      20'h0_0102

`define P8G_ADDR_W          22
`define P8G_PINS            5
`define P8G_RSVD_MASK       8'hE0
`define P8G_DIR_RST_M1_4    8'hF0
`define P8G_DIR_RST_M5_7    8'hE0
`define P8G_DATA_RST        8'hE0
`define P8G_DIR_READ        8'hFF

// Field positions in the DRAM control register
`define P8G_DRAS_LSB        0
`define P8G_REFRESH_OUTPUT_ENABLE_BIT       3

// Pin positions
`define P8G_PIN_CS0         4
`define P8G_PIN_CS1         3
`define P8G_PIN_CS2         2
`define P8G_PIN_CS3         1
`define P8G_PIN_REFRESH_STROBE_OUT        0
`define P8G_PIN_ADC_TRIGGER_IN       3

// Edges spent catching the mode strap after reset release
`define P8G_INIT_CYCLES     2'd3

`endif

//--- hw/p8g_pkg.sv
package p8g_pkg;

	typedef enum logic [1:0] {
		P8G_PIN1_NORMAL = 2'b00,
		P8G_PIN1_GPIO   = 2'b01,
		P8G_PIN1_RAS    = 2'b10
	} p8g_pin1_e;

	typedef struct packed {
		logic [4:0] out;
		logic [4:0] oe;
	} p8g_pins_s;

	typedef struct packed {
		logic [3:0] chip_select_n;
		logic [1:0] ras_n;
		logic       refresh_n;
	} p8g_strobes_s;

endpackage

//--- hw/p8g_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "p8g_map.svh"
// Overview of operation
// - five pins, each direction from one bit
// - single-chip modes: no chip-select or refresh outputs
// - single-chip: direction 1 drives data, 0 inputs
// - interrupt inputs follow enable, not direction
// - DRAM areas turn chip-select 2 into RAS, and 3 unless area select 001
// - expanded: direction 1 drives chip-selects 0 to 3
// - pin 1 becomes general output per area select
// - modes 1-4: pin 4 chip-select 0 after reset
// - mode 5: chip-select pins reset as inputs
// - refresh enable puts refresh strobe on pin 0
// - direction register write-only, reads all ones
// - bits 7 to 5 read one, ignore writes
// - reset, hardware standby load F0 or E0 direction
// - software standby keeps direction, outputs still drive
// - general output drives its data register bit
// - read gives data bit if output, else pin
// - reset, hardware standby load data E0; standby keeps

module p8g_port (
	input  wire logic                  core_clk_i,
	input  wire logic                  rst_i,
	input  wire logic [21:0]           avs_address_i,
	input  wire logic                  avs_read_i,
	input  wire logic                  avs_write_i,
	input  wire logic [3:0]            avs_byteenable_i,
	input  wire logic [31:0]           avs_writedata_i,
	output logic      [31:0]           avs_readdata_o,
	output logic                       avs_waitrequest_o,
	input  wire logic [2:0]            mode_i,
	input  wire logic                  hw_standby_i,
	input  wire logic                  sw_standby_i,
	input  wire p8g_pkg::p8g_strobes_s strobes_i,
	input  wire logic [4:0]            pin_i,
	output p8g_pkg::p8g_pins_s         pin_o,
	output logic      [3:0]            ext_irq_in_o,
	output logic                       adc_trigger_in_o
);

	logic [2:0] mode_meta;
	logic [2:0] mode_sync;
	logic       hws_meta;
	logic       hws_sync;
	logic [4:0] pin_meta;
	logic [4:0] pin_sync;
	logic [1:0] init_cnt;
	logic [2:0] mode;
	logic [4:0] pin_direction_reg;
	logic [4:0] pin_output_data_reg;
	logic [2:0] dram_area_select;
	logic       refresh_output_enable;
	logic [3:0] irq_enable_reg;
	logic       rd_valid;
	logic [4:0] port_value;
	logic [7:0] next_rdata;
	logic       init_busy;
	logic       wr_en;
	logic       expanded;
	p8g_pkg::p8g_pin1_e pin1_cfg;

	// Register decode, one flag per register
	logic       hit_dir;
	logic       hit_dat;
	logic       hit_drm;
	logic       hit_ier;
	logic       hit_sts;
	logic       rd_take;

	// Per-pin output value and enable before they are packed for the pads
	logic       pin4_out;
	logic       pin4_oe;
	logic       pin3_out;
	logic       pin3_oe;
	logic       pin2_out;
	logic       pin2_oe;
	logic       pin1_out;
	logic       pin1_oe;
	logic       pin0_out;
	logic       pin0_oe;

	// Read-back bytes of the own control registers
	logic [7:0] dram_ctrl_byte;
	logic [7:0] irq_en_byte;
	logic [7:0] status_byte;

	function automatic logic mode_low(input logic [2:0] m);
		mode_low = (m >= 3'd1) && (m <= 3'd4);
	endfunction

	// Port registers keep five bits; the upper three are fixed and never stored
	function automatic logic [4:0] pin_bits(input logic [7:0] v);
		pin_bits = v[4:0];
	endfunction

	function automatic logic [4:0] dir_reset(input logic [2:0] m);
		dir_reset = pin_bits(mode_low(m) ? `P8G_DIR_RST_M1_4 : `P8G_DIR_RST_M5_7);
	endfunction

	// A register answers only on a word-aligned byte address
	function automatic logic reg_hit(input logic [21:0] a, input logic [19:0] i);
		reg_hit = (a[21:2] == i) && (a[1:0] == 2'b00);
	endfunction

	// Mode strap, standby pin and port pins all come from outside the clock

	// Strap: only the second stage is read, by the init logic below
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			mode_meta <= 3'h0;
			mode_sync <= 3'h0;
		end else begin
			mode_meta <= mode_i;
			mode_sync <= mode_meta;
		end
	end

	// Hardware standby: a glitch that falls between two edges is not seen
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			hws_meta <= 1'b0;
			hws_sync <= 1'b0;
		end else begin
			hws_meta <= hw_standby_i;
			hws_sync <= hws_meta;
		end
	end

	// Pin levels: reads and interrupt requests lag the pads by two edges
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_meta <= 5'h00;
			pin_sync <= 5'h00;
		end else begin
			pin_meta <= pin_i;
			pin_sync <= pin_meta;
		end
	end

	// Strap is caught after release, once the synchroniser has filled
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			init_cnt <= `P8G_INIT_CYCLES;
			mode     <= 3'h0;
		end else if (init_cnt != 2'd0) begin
			init_cnt <= init_cnt - 2'd1;
			mode     <= mode_sync;
		end
	end

	assign init_busy = (init_cnt != 2'd0);
	assign expanded  = (mode >= 3'd1) && (mode <= 3'd5);

	// Misaligned or unmapped addresses hit nothing: writes vanish, reads give 0
	assign hit_dir   = reg_hit(avs_address_i, `P8G_IDX_DIRECTION);
	assign hit_dat   = reg_hit(avs_address_i, `P8G_IDX_OUT_DATA);
	assign hit_drm   = reg_hit(avs_address_i, `P8G_IDX_DRAM_CTRL);
	assign hit_ier   = reg_hit(avs_address_i, `P8G_IDX_IRQ_ENABLE);
	assign hit_sts   = reg_hit(avs_address_i, `P8G_IDX_STATUS);
	assign wr_en     = avs_write_i && !init_busy && avs_byteenable_i[0];

	// Hardware standby acts like reset; software standby leaves all alone
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_direction_reg <= pin_bits(`P8G_DIR_RST_M5_7);
		end else if (init_busy || hws_sync) begin
			pin_direction_reg <= dir_reset(init_busy ? mode_sync : mode);
		end else if (wr_en && hit_dir) begin
			pin_direction_reg <= avs_writedata_i[4:0];
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_output_data_reg <= pin_bits(`P8G_DATA_RST);
		end else if (hws_sync) begin
			pin_output_data_reg <= pin_bits(`P8G_DATA_RST);
		end else if (wr_en && hit_dat) begin
			pin_output_data_reg <= avs_writedata_i[4:0];
		end
	end

	// DRAM control: area select and refresh enable
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			dram_area_select      <= 3'h0;
			refresh_output_enable <= 1'b0;
		end else if (hws_sync) begin
			dram_area_select      <= 3'h0;
			refresh_output_enable <= 1'b0;
		end else if (wr_en && hit_drm) begin
			dram_area_select      <= avs_writedata_i[`P8G_DRAS_LSB +: 3];
			refresh_output_enable <= avs_writedata_i[`P8G_REFRESH_OUTPUT_ENABLE_BIT];
		end
	end

	// Interrupt enables, one per request line
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_enable_reg <= 4'h0;
		end else if (hws_sync) begin
			irq_enable_reg <= 4'h0;
		end else if (wr_en && hit_ier) begin
			irq_enable_reg <= avs_writedata_i[3:0];
		end
	end

	// Area select 000: plain; 001: area 2 only, pin 1 freed; others: RAS3 too
	always_comb begin
		unique case (dram_area_select)
			3'b000:  pin1_cfg = p8g_pkg::P8G_PIN1_NORMAL;
			3'b001:  pin1_cfg = p8g_pkg::P8G_PIN1_GPIO;
			default: pin1_cfg = p8g_pkg::P8G_PIN1_RAS;
		endcase
	end

	// Outputs are combinational from registers so a write shows on the pin
	// at the very edge that completes it
	// Single-chip modes keep the plain data/direction view

	// Pin 4: chip-select 0 in expanded modes, direction still decides drive
	always_comb begin
		pin4_out = pin_output_data_reg[`P8G_PIN_CS0];
		pin4_oe  = pin_direction_reg[`P8G_PIN_CS0];
		if (expanded) begin
			pin4_out = strobes_i.chip_select_n[0];
		end
	end

	// Pin 3: chip-select 1 in expanded modes
	always_comb begin
		pin3_out = pin_output_data_reg[`P8G_PIN_CS1];
		pin3_oe  = pin_direction_reg[`P8G_PIN_CS1];
		if (expanded) begin
			pin3_out = strobes_i.chip_select_n[1];
		end
	end

	// Pin 2: any DRAM area forces the row strobe out, whatever the direction
	always_comb begin
		pin2_out = pin_output_data_reg[`P8G_PIN_CS2];
		pin2_oe  = pin_direction_reg[`P8G_PIN_CS2];
		if (expanded) begin
			if (dram_area_select != 3'b000) begin
				pin2_out = strobes_i.ras_n[0];
				pin2_oe  = 1'b1;
			end else begin
				pin2_out = strobes_i.chip_select_n[2];
			end
		end
	end

	// Pin 1: chip-select 3, general port or second row strobe
	always_comb begin
		pin1_out = pin_output_data_reg[`P8G_PIN_CS3];
		pin1_oe  = pin_direction_reg[`P8G_PIN_CS3];
		if (expanded) begin
			unique case (pin1_cfg)
				p8g_pkg::P8G_PIN1_NORMAL: begin
					pin1_out = strobes_i.chip_select_n[3];
				end
				p8g_pkg::P8G_PIN1_GPIO: begin
					pin1_out = pin_output_data_reg[`P8G_PIN_CS3];
				end
				p8g_pkg::P8G_PIN1_RAS: begin
					pin1_out = strobes_i.ras_n[1];
					pin1_oe  = 1'b1;
				end
			endcase
		end
	end

	// Pin 0: refresh strobe only in expanded modes; single-chip ignores the enable
	always_comb begin
		pin0_out = pin_output_data_reg[`P8G_PIN_REFRESH_STROBE_OUT];
		pin0_oe  = pin_direction_reg[`P8G_PIN_REFRESH_STROBE_OUT];
		if (expanded && refresh_output_enable) begin
			pin0_out = strobes_i.refresh_n;
			pin0_oe  = 1'b1;
		end
	end

	assign pin_o = '{
		out: {pin4_out, pin3_out, pin2_out, pin1_out, pin0_out},
		oe:  {pin4_oe, pin3_oe, pin2_oe, pin1_oe, pin0_oe}
	};

	// Interrupts see the pin even while it is driven: software must mask
	assign ext_irq_in_o     = irq_enable_reg & ~pin_sync[3:0];
	assign adc_trigger_in_o = ~pin_sync[`P8G_PIN_ADC_TRIGGER_IN];

	// Output pins read back their register bit, input pins their level
	always_comb begin
		port_value = (pin_direction_reg & pin_output_data_reg)
			| (~pin_direction_reg & pin_sync);
	end

	assign dram_ctrl_byte = {4'h0, refresh_output_enable, dram_area_select};
	assign irq_en_byte    = {4'h0, irq_enable_reg};
	assign status_byte    = {3'b000, sw_standby_i, expanded, mode};

	always_comb begin
		next_rdata = 8'h00;
		if (hit_dir) begin
			next_rdata = `P8G_DIR_READ;
		end else if (hit_dat) begin
			next_rdata = `P8G_RSVD_MASK | {3'b000, port_value};
		end else if (hit_drm) begin
			next_rdata = dram_ctrl_byte;
		end else if (hit_ier) begin
			next_rdata = irq_en_byte;
		end else if (hit_sts) begin
			next_rdata = status_byte;
		end
	end

	// Reads take one wait cycle so read data leaves a flip-flop
	assign rd_take = avs_read_i && !init_busy && !rd_valid;

	// Toggles while a read is held, so a held read is answered every second cycle
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= rd_take;
		end
	end

	// Read data stays until the next read is answered
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			avs_readdata_o <= 32'h0000_0000;
		end else if (rd_take) begin
			avs_readdata_o <= {24'h00_0000, next_rdata};
		end
	end

	assign avs_waitrequest_o = init_busy || (avs_read_i && !rd_valid);

endmodule
`default_nettype wire

//--- testbench/p8g_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module p8g_pin_model (
	input wire p8g_pkg::p8g_pins_s	pins_i,
	input wire logic [4:0]		pull_i,
	output logic [4:0]		level_o
);
	// Released pins fall to the board pull, never keep the last driven value
	assign level_o = (pins_i.oe & pins_i.out) | (~pins_i.oe & pull_i);
endmodule
`default_nettype wire

//--- testbench/p8g_port_properties.sv
`timescale 1ns/1ps
`default_nettype none
module p8g_port_properties (
	input wire logic			core_clk_i,
	input wire logic			rst_i,
	input wire logic [21:0]			avs_address_i,
	input wire logic			avs_read_i,
	input wire logic [31:0]			avs_readdata_o,
	input wire logic			avs_waitrequest_o,
	input wire logic [2:0]			mode_i,
	input wire logic [4:0]			pin_i,
	input wire p8g_pkg::p8g_pins_s		pin_o,
	input wire logic [3:0]			ext_irq_in_o,
	input wire logic			adc_trigger_in_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	wire logic done = avs_read_i && !avs_waitrequest_o;
	a_rd_one_wait: assert property (done |-> $past(avs_waitrequest_o))
		else $error("read answered with no wait cycle");
	a_rd_upper_zero: assert property (done |-> avs_readdata_o[31:8] == 24'h00_0000)
		else $error("read data upper bits set");
	a_dir_reads_ones: assert property (done && avs_address_i == 22'h3B_801C |-> avs_readdata_o[7:0] == 8'hFF)
		else $error("direction read not all ones");
	a_data_rsvd_ones: assert property (done && avs_address_i == 22'h3F_FF5C |-> avs_readdata_o[7:5] == 3'b111)
		else $error("data reserved bits not one");
	a_irq_pin_low: assert property (!$past(rst_i, 2) && ext_irq_in_o != 4'h0 |-> (ext_irq_in_o & $past(pin_i[3:0], 2)) == 4'h0)
		else $error("interrupt request on a high pin");
	a_adc_trigger_in_pin_level: assert property (!$past(rst_i, 2) |-> adc_trigger_in_o == !$past(pin_i[3], 2))
		else $error("trigger input not following pin");
	a_reset_all_inputs: assert property ($fell(rst_i) |-> pin_o.oe == 5'h00)
		else $error("pin driven during reset");
	a_boot_dir_mode: assert property ($fell(rst_i) |-> ##4 pin_o.oe[4:1] == ((mode_i inside {[3'd1:3'd4]}) ? 4'h8 : 4'h0))
		else $error("direction after reset wrong for mode");
	cover property (done && avs_address_i == 22'h3B_801C);
	cover property (ext_irq_in_o != 4'h0);
	cover property (pin_o.oe == 5'h1F);
endmodule
bind p8g_port p8g_port_properties u_p8g_port_properties (.core_clk_i, .rst_i, .avs_address_i,
	.avs_read_i, .avs_readdata_o, .avs_waitrequest_o, .mode_i, .pin_i, .pin_o, .ext_irq_in_o,
	.adc_trigger_in_o);
`default_nettype wire

//--- testbench/tb_p8g_port.sv
`timescale 1ns/1ps
`default_nettype none
module tb_p8g_port;
	localparam logic [21:0] addr_dir = 22'h3B_801C;
	localparam logic [21:0] addr_dat = 22'h3F_FF5C;
	localparam logic [21:0] addr_drm = 22'h00_0400;
	logic			clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, hws = 1'b0, sws = 1'b0;
	logic [21:0]		adr = 22'h00_0000;
	logic [31:0]		wd = 32'h0000_0000, q, rdata;
	logic [2:0]		mode = 3'h6;
	logic [4:0]		pull = 5'h1A, lvl;
	logic [3:0]		irq;
	logic			wreq, adc_trigger_in;
	int			failures = 0, num_checks = 0;
	p8g_pkg::p8g_strobes_s	stb = 7'h00;
	p8g_pkg::p8g_pins_s	pins;
	p8g_port u_p8g_port (.core_clk_i(clk), .rst_i(rst), .avs_address_i(adr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_byteenable_i(4'h1), .avs_writedata_i(wd), .avs_readdata_o(rdata),
		.avs_waitrequest_o(wreq), .mode_i(mode), .hw_standby_i(hws), .sw_standby_i(sws),
		.strobes_i(stb), .pin_i(lvl), .pin_o(pins), .ext_irq_in_o(irq), .adc_trigger_in_o(adc_trigger_in));
	p8g_pin_model u_p8g_pin_model (.pins_i(pins), .pull_i(pull), .level_o(lvl));
	initial begin
		forever #20 clk = ~clk;
	end
	task automatic finish_test;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		num_checks++;
		if (s !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	// Request stays put until the edge that sees the stall gone
	task automatic bus(input logic w, input logic [21:0] a, input logic [7:0] d);
		int n;
		@(posedge clk);
		adr <= a;
		wd <= {24'h00_0000, d};
		wr <= w;
		rd <= !w;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wreq !== 1'b0 && n < 50);
		if (wreq !== 1'b0) begin
			failures++;
			finish_test();
		end else begin
			q = rdata;
			wr <= 1'b0;
			rd <= 1'b0;
		end
	endtask
	task automatic boot(input logic [2:0] m);
		rst <= 1'b1;
		mode <= m;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (5) @(posedge clk);
	endtask
	task automatic t_single;
		boot(3'h6);
		bus(1'b1, addr_dat, 8'h15);
		bus(1'b1, addr_dir, 8'h0F);
		bus(1'b1, addr_drm, 8'h08);
		bus(1'b1, addr_drm + 22'h00_0004, 8'h0F);
		@(negedge clk);
		chk("oe", 8'(pins.oe), 8'h0F);
		chk("out", 8'(pins.out & 5'h0F), 8'h05);
		chk("irq", 8'(irq), 8'h0A);
		chk("adc_trigger_in", 8'(adc_trigger_in), 8'h01);
		bus(1'b0, addr_dir, 8'h00);
		chk("dir", q[7:0], 8'hFF);
		bus(1'b0, addr_dat, 8'h00);
		chk("dat", q[7:0], 8'hF5);
		bus(1'b0, 22'h00_0800, 8'h00);
		chk("gap", q[7:0], 8'h00);
		sws <= 1'b1;
		bus(1'b0, addr_dat, 8'h00);
		chk("swsb", q[7:0], 8'hF5);
		chk("swoe", 8'(pins.oe), 8'h0F);
		sws <= 1'b0;
		hws <= 1'b1;
		repeat (4) @(posedge clk);
		hws <= 1'b0;
		repeat (4) @(posedge clk);
		bus(1'b0, addr_dat, 8'h00);
		chk("hwsb", q[7:0], 8'hFA);
	endtask
	task automatic t_exp;
		boot(3'h3);
		stb <= 7'h7C;
		@(negedge clk);
		chk("boot", 8'(pins.oe), 8'h10);
		bus(1'b0, addr_drm + 22'h00_0008, 8'h00);
		chk("sts", q[7:0], 8'h0B);
		bus(1'b1, addr_dat, 8'h05);
		bus(1'b1, addr_dir, 8'h1F);
		bus(1'b1, addr_drm, 8'h08);
		@(negedge clk);
		chk("cs", 8'(pins.out), 8'h1E);
		bus(1'b1, addr_drm, 8'h01);
		@(negedge clk);
		chk("ras2", 8'(pins.out), 8'h19);
		bus(1'b1, addr_drm, 8'h02);
		@(negedge clk);
		chk("ras3", 8'(pins.out), 8'h1B);
		bus(1'b1, addr_dir, 8'h00);
		@(negedge clk);
		chk("in", 8'(pins.oe), 8'h06);
	endtask
	initial begin
		t_single();
		t_exp();
		boot(3'h5);
		@(negedge clk);
		chk("m5", 8'(pins.oe), 8'h00);
		finish_test();
	end
endmodule
`default_nettype wire
